/* File: scc_pkg.sv */
// shared constants and types for the sleep clock calibration block
package scc_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] SCC_IDX_SRC = 12'h207;
  localparam logic [11:0] SCC_IDX_TUNE = 12'h208;
  localparam logic [11:0] SCC_IDX_CNT_LO = 12'h209;
  localparam logic [11:0] SCC_IDX_CNT_MID = 12'h20A;
  localparam logic [11:0] SCC_IDX_CNT_HI = 12'h20B;
  localparam logic [11:0] SCC_IDX_STATE = 12'h20F;
  localparam logic [11:0] SCC_IDX_DIV = 12'h220;
  localparam logic [11:0] SCC_IDX_INT_STAT = 12'h230;
  localparam logic [11:0] SCC_IDX_INT_MASK = 12'h231;
  // field positions
  localparam int SCC_SEL_LSB = 6;
  localparam int SCC_VCO_BIT = 4;
  localparam int SCC_GO_BIT = 4;
  localparam int SCC_DONE_BIT = 7;
  localparam int SCC_RSV_LSB = 5;
  localparam int SCC_STATE_LSB = 5;
  localparam int SCC_DIV_W = 5;
  // reset values
  localparam logic [7:0] SCC_SRC_RST = 8'h00;
  localparam logic [7:0] SCC_TUNE_RST = 8'h00;
  localparam logic [7:0] SCC_DIV_RST = 8'h00;
  localparam logic [31:0] SCC_ZERO32 = 32'h0000_0000;
  // sleep source codes
  localparam logic [1:0] SCC_SRC_INTERNAL = 2'h2;
  localparam logic [1:0] SCC_SRC_EXTERNAL = 2'h1;
  // measurement
  localparam int SCC_CNT_W = 20;
  localparam int SCC_PERIODS = 16;
  localparam logic [3:0] SCC_EDGE_LAST = 4'(SCC_PERIODS - 1);
  localparam int SCC_CLK_PERIOD_NS = 25;
  localparam int SCC_TICK_NS = 50;
  localparam int SCC_TICK_CYCLES = (SCC_TICK_NS + SCC_CLK_PERIOD_NS - 1) / SCC_CLK_PERIOD_NS;
  localparam logic [3:0] SCC_TICK_LAST = 4'(SCC_TICK_CYCLES - 1);
  // interrupt status layout
  localparam int SCC_INT_DONE_BIT = 0;

  typedef enum logic [2:0] {
    SCC_RF_RESET,
    SCC_RF_FILTER_CAL,
    SCC_RF_SLEEP,
    SCC_RF_VCO_CAL,
    SCC_RF_TX,
    SCC_RF_RX,
    SCC_RF_TURN_A,
    SCC_RF_TURN_B
  } scc_radio_state_t;

  typedef enum logic [1:0] {
    SCC_M_IDLE,
    SCC_M_ALIGN,
    SCC_M_COUNT
  } scc_meas_state_t;
endpackage

/* File: scc_meas_if.sv */
// signals between the control block, the sleep clock former and the counter
`timescale 1ns/1ps
interface scc_meas_if;
  logic [1:0] sel;
  logic [4:0] div_exp;
  logic sleep_edge;
  logic start;
  logic busy;
  logic done;
  logic [19:0] count;
  modport clk_src (input sel, input div_exp, output sleep_edge);
  modport meas (input sleep_edge, input start, output busy, output done, output count);
  modport ctl (output sel, output div_exp, output start, input busy, input done, input count,
    input sleep_edge);
endinterface

/* File: scc_sleep_clk.sv */
// sleep oscillator selection, synchronisation and power-of-two division
`timescale 1ns/1ps
module scc_sleep_clk
  import scc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic osc_int,
  input wire logic osc_ext,
  scc_meas_if.clk_src m
);
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic prev;
    logic [31:0] divcnt;
    logic edge_out;
  } scc_sclk_t;

  scc_sclk_t r_reg;
  scc_sclk_t r_next;

  function automatic logic [31:0] div_mask(input logic [4:0] e);
    div_mask = (32'h0000_0001 << e) - 32'h0000_0001;
  endfunction

  logic lvl;
  logic src_ok;

  always_comb
  begin
    r_next = r_reg;
    r_next.sync1 = {osc_ext, osc_int};
    r_next.sync2 = r_reg.sync1;
    src_ok = (m.sel == SCC_SRC_INTERNAL) || (m.sel == SCC_SRC_EXTERNAL); // see RULE_06
    lvl = (m.sel == SCC_SRC_INTERNAL) ? r_reg.sync2[0] :
          (m.sel == SCC_SRC_EXTERNAL) ? r_reg.sync2[1] : 1'b0;
    r_next.prev = lvl;
    r_next.edge_out = 1'b0;
    if (!src_ok)
    begin
      r_next.divcnt = SCC_ZERO32;
    end
    else if (lvl && !r_reg.prev)
    begin
      // one low power clock period per 2**exponent source periods
      if (r_reg.divcnt >= div_mask(m.div_exp)) // see RULE_12
      begin
        r_next.divcnt = SCC_ZERO32;
        r_next.edge_out = 1'b1;
      end
      else
      begin
        r_next.divcnt = r_reg.divcnt + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

  assign m.sleep_edge = r_reg.edge_out;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  no_src_quiet_a: assert property (!src_ok |=> !m.sleep_edge) // see RULE_06
    else $error("low power clock edge with no source selected");
  div_edge_a: assert property (m.sleep_edge |-> $past(lvl) && !$past(r_reg.prev)) // see RULE_12
    else $error("low power clock edge without source edge");
endmodule

/* File: scc_measure.sv */
// counts 50 ns ticks over sixteen low power clock periods
`timescale 1ns/1ps
module scc_measure
  import scc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  scc_meas_if.meas m
);
  typedef struct packed {
    scc_meas_state_t state;
    logic [19:0] count;
    logic [3:0] edges;
    logic [3:0] tick_cnt;
    logic done;
  } scc_meas_t;

  scc_meas_t r_reg;
  scc_meas_t r_next;
  logic tick;

  always_comb
  begin
    r_next = r_reg;
    r_next.done = 1'b0;
    tick = (r_reg.tick_cnt == SCC_TICK_LAST); // see RULE_03
    r_next.tick_cnt = tick ? 4'h0 : r_reg.tick_cnt + 4'h1;
    case (r_reg.state)
      SCC_M_IDLE:
      begin
        r_next.tick_cnt = 4'h0;
      end
      SCC_M_ALIGN:
      begin
        r_next.tick_cnt = 4'h0;
        if (m.sleep_edge)
        begin
          r_next.state = SCC_M_COUNT;
          r_next.edges = 4'h0;
        end
      end
      SCC_M_COUNT:
      begin
        if (tick)
          r_next.count = r_reg.count + 20'h0_0001; // see RULE_03
        if (m.sleep_edge)
        begin
          r_next.edges = r_reg.edges + 4'h1;
          if (r_reg.edges == SCC_EDGE_LAST) // see RULE_02
          begin
            r_next.state = SCC_M_IDLE;
            r_next.done = 1'b1;
          end
        end
      end
      default:
      begin
        r_next.state = SCC_M_IDLE;
      end
    endcase
    if (m.start)
    begin
      r_next.state = SCC_M_ALIGN;
      r_next.count = 20'h0_0000;
      r_next.edges = 4'h0;
      r_next.done = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_reg <= '{state: SCC_M_IDLE, default: '0};
    else
      r_reg <= r_next;
  end

  assign m.busy = (r_reg.state != SCC_M_IDLE);
  assign m.done = r_reg.done;
  assign m.count = r_reg.count; // see RULE_01

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  tick_step_a: assert property ((r_reg.state == SCC_M_COUNT) // see RULE_03
    && tick && !m.start |=> m.count == $past(m.count) + 20'h0_0001)
    else $error("count did not advance on tick");
  no_tick_hold_a: assert property ((r_reg.state == SCC_M_COUNT) // see RULE_03
    && !tick && !m.start |=> $stable(m.count))
    else $error("count moved between ticks");
  done_after16_a: assert property (m.done |-> $past(r_reg.edges) == SCC_EDGE_LAST) // see RULE_02
    else $error("done not after sixteenth period");
endmodule

/* File: scc_top.sv */
// register front end of the sleep clock calibration block over apb
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
// Behaviour
// RULE_01: twenty bit read only measurement count
// RULE_02: one run spans sixteen low power periods
// RULE_03: count advances once per 50 ns
// RULE_04: period follows selected source and divider
// RULE_05: low and middle count bytes in bits 7:0
// RULE_06: source code 10 internal, 01 external
// RULE_07: software should set vco tune bit
// RULE_08: software writes reserved bits as zero
// RULE_09: unimplemented bits always read zero; stored reserved and unused bits read back as written
// RULE_10: go starts run, self clears, done flags
// RULE_11: radio state field in bits 7:5
// RULE_12: source divided by two to exponent
// RULE_13: internal source needs divider exponent one
module scc_top
  import scc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic vco_tune_ctrl,
  input wire logic osc_int,
  input wire logic osc_ext,
  input wire logic [2:0] radio_fsm_state
);
  typedef struct packed {
    logic [7:0] src_ctrl;
    logic [7:0] tune_ctrl;
    logic [7:0] div_ctrl;
    logic [1:0] hi_rsv;
    logic done_flag;
    logic int_stat;
    logic int_mask;
    logic start;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
  } scc_regs_t;

  scc_regs_t r_reg;
  scc_regs_t r_next;

  scc_meas_if m ();

  scc_sleep_clk u_sleep_clk (
    .pclk(pclk),
    .presetn(presetn),
    .osc_int(osc_int),
    .osc_ext(osc_ext),
    .m(m.clk_src)
  );

  scc_measure u_measure (
    .pclk(pclk),
    .presetn(presetn),
    .m(m.meas)
  );

  function automatic logic [11:0] reg_index(input logic [13:0] a);
    reg_index = a[13:2];
  endfunction

  function automatic logic is_mapped(input logic [13:0] a);
    logic [11:0] i;
    i = reg_index(a);
    is_mapped = (a[1:0] == 2'h0) &&
      ((i == SCC_IDX_SRC) || (i == SCC_IDX_TUNE) || (i == SCC_IDX_CNT_LO) ||
       (i == SCC_IDX_CNT_MID) || (i == SCC_IDX_CNT_HI) || (i == SCC_IDX_STATE) ||
       (i == SCC_IDX_DIV) || (i == SCC_IDX_INT_STAT) || (i == SCC_IDX_INT_MASK));
  endfunction

  logic setup_ph;
  logic acc_done;
  logic wr_ok;
  logic rd_ok;
  logic go_now;
  logic rd_clear;
  logic mask_wr;
  logic [11:0] idx;
  logic [7:0] rd_byte;

  // read value; bits with no storage are zero, stored reserved and unused bits read back as written
  always_comb
  begin
    idx = reg_index(paddr);
    rd_byte = 8'h00;
    case (idx)
      SCC_IDX_SRC:
        rd_byte = r_reg.src_ctrl;
      SCC_IDX_TUNE:
        rd_byte = r_reg.tune_ctrl;
      SCC_IDX_CNT_LO:
        rd_byte = m.count[7:0]; // see RULE_05
      SCC_IDX_CNT_MID:
        rd_byte = m.count[15:8]; // see RULE_05
      SCC_IDX_CNT_HI:
        rd_byte = {r_reg.done_flag, r_reg.hi_rsv, m.busy, m.count[19:16]}; // see RULE_10
      SCC_IDX_STATE:
        rd_byte = {radio_fsm_state, 5'h00}; // see RULE_11 and RULE_09
      SCC_IDX_DIV:
        rd_byte = r_reg.div_ctrl;
      SCC_IDX_INT_STAT:
        rd_byte = {7'h00, r_reg.int_stat};
      SCC_IDX_INT_MASK:
        rd_byte = {7'h00, r_reg.int_mask};
      default:
        rd_byte = 8'h00; // see RULE_09
    endcase
  end

  always_comb
  begin
    r_next = r_reg;
    setup_ph = psel && !penable;
    acc_done = psel && penable && r_reg.pready;
    wr_ok = acc_done && pwrite && !r_reg.pslverr;
    rd_ok = acc_done && !pwrite && !r_reg.pslverr;
    go_now = wr_ok && (idx == SCC_IDX_CNT_HI) && pwdata[SCC_GO_BIT]; // see RULE_10
    rd_clear = rd_ok && (idx == SCC_IDX_INT_STAT);
    mask_wr = wr_ok && (idx == SCC_IDX_INT_MASK);
    // one wait-free access phase: pready high in the first access cycle
    r_next.pready = setup_ph;
    r_next.start = go_now;
    if (setup_ph)
    begin
      r_next.pslverr = !is_mapped(paddr);
      r_next.prdata = is_mapped(paddr) ? {24'h00_0000, rd_byte} : SCC_ZERO32;
    end
    if (wr_ok)
    begin
      case (idx)
        SCC_IDX_SRC:
          r_next.src_ctrl = pwdata[7:0]; // see RULE_06
        SCC_IDX_TUNE:
          r_next.tune_ctrl = pwdata[7:0];
        SCC_IDX_DIV:
          r_next.div_ctrl = pwdata[7:0]; // see RULE_12
        SCC_IDX_CNT_HI:
          r_next.hi_rsv = pwdata[SCC_RSV_LSB +: 2];
        SCC_IDX_INT_MASK:
          r_next.int_mask = pwdata[SCC_INT_DONE_BIT];
        default:
          r_next.hi_rsv = r_reg.hi_rsv;
      endcase
    end
    // a completion in the same cycle as a clear wins
    r_next.done_flag = (r_reg.done_flag && !go_now) || m.done; // see RULE_10
    // only a status bit that the read returned is cleared
    r_next.int_stat = (r_reg.int_stat && !(rd_clear && r_reg.prdata[SCC_INT_DONE_BIT])) ||
      m.done;
    r_next.irq = r_next.int_stat && r_next.int_mask;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_reg <= '0;
      r_reg.src_ctrl <= SCC_SRC_RST;
      r_reg.tune_ctrl <= SCC_TUNE_RST;
      r_reg.div_ctrl <= SCC_DIV_RST;
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // source and divider steer the period that is measured
  assign m.sel = r_reg.src_ctrl[SCC_SEL_LSB +: 2]; // see RULE_04
  assign m.div_exp = r_reg.div_ctrl[SCC_DIV_W-1:0]; // see RULE_04
  assign m.start = r_reg.start;

  assign prdata = r_reg.prdata;
  assign pready = r_reg.pready;
  assign pslverr = r_reg.pslverr;
  assign irq = r_reg.irq;
  assign vco_tune_ctrl = r_reg.tune_ctrl[SCC_VCO_BIT];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence go_write_s;
    psel && penable && pready && pwrite && !pslverr &&
      (paddr[13:2] == SCC_IDX_CNT_HI) && pwdata[SCC_GO_BIT];
  endsequence

  sequence run_begin_s;
    m.start ##1 m.busy;
  endsequence

  sequence setup_rd_s(logic [11:0] i);
    psel && !penable && !pwrite && (paddr[1:0] == 2'h0) && (paddr[13:2] == i);
  endsequence

  // completed write access to one register index
  sequence wr_hit_s(logic [11:0] i);
    psel && penable && pready && pwrite && !pslverr && (paddr[13:2] == i);
  endsequence

  sequence setup_any_s;
    psel && !penable;
  endsequence

  // completion pulse, then ready flag and status bit together
  sequence finish_s;
    m.done ##1 (r_reg.done_flag && r_reg.int_stat);
  endsequence

  sequence run_hold_s;
    m.busy ##1 m.busy;
  endsequence

  // run control
  go_start_a: assert property (go_write_s |=> run_begin_s) // see RULE_10
    else $error("go write did not start a run");

  go_clear_flag_a: assert property ((go_write_s and !m.done) // see RULE_10
    |=> !r_reg.done_flag)
    else $error("ready flag not cleared by go");

  done_flag_set_a: assert property (m.done |=> r_reg.done_flag [*2] or // see RULE_10
    (r_reg.done_flag ##1 1'b1))
    else $error("ready flag not set on completion");

  go_self_clear_a: assert property (m.start |=> !m.start) // see RULE_10
    else $error("go pulse lasted longer than one cycle");

  start_zero_a: assert property (m.start |=> m.count == 20'h0_0000) // see RULE_10
    else $error("count not cleared at run start");

  run_hold_a: assert property (m.start |=> run_hold_s) // see RULE_02
    else $error("run ended too soon after start");

  busy_end_done_a: assert property ($fell(m.busy) |-> m.done) // see RULE_10
    else $error("run left busy without completion");

  finish_a: assert property (m.done |-> finish_s) // see RULE_10
    else $error("completion not reported in flag and status");

  done_idle_a: assert property (m.done |-> !m.busy) // see RULE_10
    else $error("completion while still busy");

  hold_go_a: assert property ((wr_hit_s(SCC_IDX_CNT_HI) and !pwdata[SCC_GO_BIT]) // see RULE_10
    |=> !m.start)
    else $error("run started without go bit");

  // register access
  src_write_a: assert property (wr_hit_s(SCC_IDX_SRC) // see RULE_06
    |=> r_reg.src_ctrl == $past(pwdata[7:0]))
    else $error("source register write lost");

  div_write_a: assert property (wr_hit_s(SCC_IDX_DIV) // see RULE_12
    |=> m.div_exp == $past(pwdata[SCC_DIV_W-1:0]))
    else $error("divider exponent write lost");

  tune_write_a: assert property (wr_hit_s(SCC_IDX_TUNE)
    |=> vco_tune_ctrl == $past(pwdata[SCC_VCO_BIT]))
    else $error("tune bit write lost");

  rsv_keep_a: assert property (wr_hit_s(SCC_IDX_CNT_HI)
    |=> r_reg.hi_rsv == $past(pwdata[SCC_RSV_LSB +: 2]))
    else $error("stored high register bits lost");

  err_no_write_a: assert property (psel && penable && pready && pwrite && pslverr
    |=> $stable(r_reg.src_ctrl) && $stable(r_reg.tune_ctrl) && $stable(r_reg.div_ctrl))
    else $error("refused write changed a register");

  src_read_a: assert property (setup_rd_s(SCC_IDX_SRC) // see RULE_06
    |=> prdata == {24'h00_0000, $past(r_reg.src_ctrl)})
    else $error("source register read mismatch");

  div_read_a: assert property (setup_rd_s(SCC_IDX_DIV) // see RULE_12
    |=> prdata == {24'h00_0000, $past(r_reg.div_ctrl)})
    else $error("divider register read mismatch");

  lo_read_a: assert property (setup_rd_s(SCC_IDX_CNT_LO) // see RULE_05
    |=> prdata == {24'h00_0000, $past(m.count[7:0])})
    else $error("low count read mismatch");

  mid_read_a: assert property (setup_rd_s(SCC_IDX_CNT_MID) // see RULE_05
    |=> prdata == {24'h00_0000, $past(m.count[15:8])})
    else $error("middle count read mismatch");

  hi_read_a: assert property (setup_rd_s(SCC_IDX_CNT_HI) // see RULE_01
    |=> prdata[3:0] == $past(m.count[19:16]) && prdata[31:8] == 24'h00_0000)
    else $error("high count read mismatch");

  hi_flags_a: assert property (setup_rd_s(SCC_IDX_CNT_HI) // see RULE_10
    |=> prdata[7] == $past(r_reg.done_flag) && prdata[4] == $past(m.busy))
    else $error("ready or busy bit read mismatch");

  state_read_a: assert property (setup_rd_s(SCC_IDX_STATE) // see RULE_11
    |=> prdata == {24'h00_0000, $past(radio_fsm_state), 5'h00})
    else $error("radio state read mismatch");

  unmapped_zero_a: assert property (psel && !penable && !is_mapped(paddr) // see RULE_09
    |=> pslverr && prdata == SCC_ZERO32 && pready)
    else $error("unmapped access not answered with zero and error");

  upper_zero_a: assert property (prdata[31:8] == 24'h00_0000) // see RULE_09
    else $error("unused read data bits not zero");

  stat_read_a: assert property (setup_rd_s(SCC_IDX_INT_STAT)
    |=> prdata == {24'h00_0000, 7'h00, $past(r_reg.int_stat)})
    else $error("status register read mismatch");

  mask_read_a: assert property (setup_rd_s(SCC_IDX_INT_MASK)
    |=> prdata == {24'h00_0000, 7'h00, $past(r_reg.int_mask)})
    else $error("mask register read mismatch");

  // bus timing: no wait states, read data holds until the next setup
  ready_first_a: assert property (setup_any_s |=> pready)
    else $error("no answer in first access cycle");

  ready_idle_a: assert property (!setup_ph |=> !pready)
    else $error("answer without a setup cycle");

  rdata_hold_a: assert property (!setup_ph |=> $stable(prdata) && $stable(pslverr))
    else $error("read data changed outside a setup");

  // interrupt and idle count
  stat_set_a: assert property (m.done |=> r_reg.int_stat)
    else $error("status bit not set on completion");

  stat_clear_a: assert property (rd_clear && prdata[SCC_INT_DONE_BIT] && !m.done
    |=> !r_reg.int_stat)
    else $error("status bit survived its read");

  irq_level_a: assert property (r_reg.int_stat && r_reg.int_mask && !rd_clear && !mask_wr
    |=> irq)
    else $error("interrupt missing for unmasked status");

  irq_masked_a: assert property (!r_reg.int_mask && !mask_wr |=> !irq)
    else $error("interrupt raised while masked");

  ro_count_a: assert property (!m.busy && !m.start |=> $stable(m.count)) // see RULE_01
    else $error("count changed outside a run");
endmodule

/* File: testbench.sv */
// self-checking bench for the sleep clock calibration register block
`timescale 1ns/1ps
module testbench
  import scc_pkg::*;
;
  localparam int INT_HALF = 10;
  localparam int EXT_HALF = 25;
  localparam int LIMIT = 50000;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [13:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic vco_tune_ctrl;
  logic osc_int;
  logic osc_ext;
  logic [2:0] radio_fsm_state;
  int errors;
  int tests_run;
  int cycles;
  int int_cnt;
  int ext_cnt;
  logic [11:0] rst_list [9];

  scc_top i_scc_top (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .irq(irq),
    .vco_tune_ctrl(vco_tune_ctrl),
    .osc_int(osc_int),
    .osc_ext(osc_ext),
    .radio_fsm_state(radio_fsm_state)
  );

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // free running oscillators, scaled down to keep runs short
  always @(posedge pclk)
  begin
    int_cnt <= (int_cnt == INT_HALF - 1) ? 0 : int_cnt + 1;
    ext_cnt <= (ext_cnt == EXT_HALF - 1) ? 0 : ext_cnt + 1;
    if (int_cnt == INT_HALF - 1)
      osc_int <= ~osc_int;
    if (ext_cnt == EXT_HALF - 1)
      osc_ext <= ~osc_ext;
  end

  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      errors++;
      stop_test();
    end
  end

  function automatic int ticks(input int half, input int dv);
    return SCC_PERIODS * 2 * half * (1 << dv) * SCC_CLK_PERIOD_NS / SCC_TICK_NS;
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic [11:0] idx, input logic wr_en, input logic [7:0] d,
    output logic [31:0] rd_data, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      @(posedge pclk);
    end
    chk("wait states", n, 32'h0000_0000);
    rd_data = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(idx, 1'b1, d, r, e);
    chk("write error", {31'h0, e}, 32'h0000_0000);
  endtask

  task automatic rd(input logic [11:0] idx, output logic [31:0] r);
    logic e;
    apb(idx, 1'b0, 8'h00, r, e);
    chk("read error", {31'h0, e}, 32'h0000_0000);
  endtask

  task automatic rchk(input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    rd(idx, r);
    chk($sformatf("register %h", idx), r, exp);
  endtask

  task automatic meas(input logic [1:0] src, input logic [7:0] dv, input int exp_ticks);
    logic [31:0] lo;
    logic [31:0] mid;
    logic [31:0] hi;
    int n;
    int cnt;
    wr(SCC_IDX_SRC, {src, 6'h00});
    wr(SCC_IDX_DIV, dv);
    wr(SCC_IDX_CNT_HI, 8'h10);
    repeat (2) @(posedge pclk);
    rd(SCC_IDX_CNT_HI, hi);
    chk("busy during run", hi & 32'h0000_0090, 32'h0000_0010);
    hi = 32'h0000_0000;
    n = 0;
    while (hi[7] !== 1'b1 && n < 3000)
    begin
      rd(SCC_IDX_CNT_HI, hi);
      n++;
    end
    chk("done flag", hi & 32'hFFFF_FF90, 32'h0000_0080);
    rd(SCC_IDX_CNT_LO, lo);
    rd(SCC_IDX_CNT_MID, mid);
    chk("count byte spare bits", (lo | mid) & 32'hFFFF_FF00, 32'h0000_0000);
    cnt = int'({hi[3:0], mid[7:0], lo[7:0]});
    chk($sformatf("count %0d near %0d", cnt, exp_ticks),
      {31'h0, (cnt >= exp_ticks - 1) && (cnt <= exp_ticks + 1)},
      32'h0000_0001);
  endtask

  task automatic stop_test();
    $display("counts: %0d errors, %0d checks", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    logic [31:0] r;
    logic e;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0000;
    pwdata = 32'h0000_0000;
    osc_int = 1'b0;
    osc_ext = 1'b0;
    radio_fsm_state = 3'h0;
    errors = 0;
    tests_run = 0;
    cycles = 0;
    int_cnt = 0;
    ext_cnt = 0;
    rst_list = '{SCC_IDX_SRC, SCC_IDX_TUNE, SCC_IDX_CNT_LO, SCC_IDX_CNT_MID, SCC_IDX_CNT_HI,
      SCC_IDX_STATE, SCC_IDX_DIV, SCC_IDX_INT_STAT, SCC_IDX_INT_MASK};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_list[i])
      rchk(rst_list[i], SCC_ZERO32);
    chk("vco pin at reset", {31'h0, vco_tune_ctrl}, 32'h0000_0000);
    wr(SCC_IDX_CNT_LO, 8'hFF);
    rchk(SCC_IDX_CNT_LO, SCC_ZERO32);
    wr(SCC_IDX_SRC, 8'h80);
    rchk(SCC_IDX_SRC, 32'h0000_0080);
    wr(SCC_IDX_TUNE, 8'h10);
    rchk(SCC_IDX_TUNE, 32'h0000_0010);
    chk("vco pin set", {31'h0, vco_tune_ctrl}, 32'h0000_0001);
    for (int k = 0; k < 8; k++)
    begin
      radio_fsm_state <= k[2:0];
      rchk(SCC_IDX_STATE, {24'h00_0000, k[2:0], 5'h00});
    end
    apb(12'h210, 1'b0, 8'h00, r, e);
    chk("unmapped error", {31'h0, e}, 32'h0000_0001);
    chk("unmapped data", r, SCC_ZERO32);
    wr(SCC_IDX_INT_MASK, 8'h01);
    meas(SCC_SRC_INTERNAL, 8'h01, ticks(INT_HALF, 1));
    chk("irq unmasked", {31'h0, irq}, 32'h0000_0001);
    rchk(SCC_IDX_INT_STAT, 32'h0000_0001);
    rchk(SCC_IDX_INT_STAT, SCC_ZERO32);
    @(posedge pclk);
    chk("irq after clear", {31'h0, irq}, 32'h0000_0000);
    wr(SCC_IDX_INT_MASK, 8'h00);
    meas(SCC_SRC_EXTERNAL, 8'h00, ticks(EXT_HALF, 0));
    chk("irq masked", {31'h0, irq}, 32'h0000_0000);
    rchk(SCC_IDX_INT_STAT, 32'h0000_0001);
    meas(SCC_SRC_EXTERNAL, 8'h02, ticks(EXT_HALF, 2));
    stop_test();
  end
endmodule
